// ===== rtl/fesr_map.svh
// Register offsets, field positions, reset values and address constants of the flash control block
`ifndef FESR_MAP_SVH
`define FESR_MAP_SVH

`define FESR_OFF_ERR_STAT 12'h000
`define FESR_OFF_ERASE_SEL 12'h004
`define FESR_OFF_OVL_CTRL 12'h008
`define FESR_OFF_PWR_CTRL 12'h00C
`define FESR_OFF_MODE_CTRL 12'h010
`define FESR_OFF_IRQ_STAT 12'h014
`define FESR_OFF_IRQ_EN 12'h018
`define FESR_OFF_IRQ_CLR 12'h01C

`define FESR_ERR_FLAG_BIT 7
`define FESR_PDI_BIT 7
`define FESR_OVL_EN_BIT 3
`define FESR_OVL_SEL_HI_BIT 2
`define FESR_OVL_SEL_LO_BIT 1
`define FESR_OVL_RSV_HI 5
`define FESR_OVL_RSV_LO 4
`define FESR_SWE_BIT 6
`define FESR_ERASE_TRIG_BIT 1
`define FESR_PROG_TRIG_BIT 0

`define FESR_RST8 8'h00
`define FESR_IRQ_RST 3'h0
`define FESR_IRQ_W 3

`define FESR_IRQ_ERROR 0
`define FESR_IRQ_BLOCKED 1
`define FESR_IRQ_PDN 2

`define FESR_RAM_WIN_BASE 24'hFFE000
`define FESR_EB0_BASE 24'h000000
`define FESR_EB1_BASE 24'h000400
`define FESR_EB2_BASE 24'h000800
`define FESR_EB3_BASE 24'h000C00
`define FESR_EB4_BASE 24'h001000
`define FESR_EB5_BASE 24'h008000
`define FESR_EB6_BASE 24'h00C000
`define FESR_EB7_BASE 24'h00E000
`define FESR_EB0_LAST 24'h0003FF
`define FESR_EB1_LAST 24'h0007FF
`define FESR_EB2_LAST 24'h000BFF
`define FESR_EB3_LAST 24'h000FFF
`define FESR_EB4_LAST 24'h007FFF
`define FESR_EB5_LAST 24'h00BFFF
`define FESR_EB6_LAST 24'h00DFFF
`define FESR_EB7_LAST 24'h00FFFF

`endif

// ===== rtl/fesr_pkg.sv
// Types shared by the flash control block
package fesr_pkg;
	typedef enum logic [1:0] {
		FESR_IDLE = 2'h0,
		FESR_SETUP = 2'h1,
		FESR_ACCESS = 2'h3
	} fesr_apb_state_t;
	typedef logic [23:0] fesr_addr_t;
endpackage

// ===== rtl/fesr_erase_decode.sv
// Decodes the one-hot erase block selection into a flash address range
`timescale 1ns/1ps
`include "fesr_map.svh"
module fesr_erase_decode
	import fesr_pkg::*;
(
	input wire logic [7:0] erase_block_select, // One-hot selection
	output fesr_addr_t erase_base, // First byte of chosen block
	output fesr_addr_t erase_last, // Last byte of chosen block
	output logic erase_valid // Exactly one block chosen
);
	always_comb begin
		erase_valid = 1'b1;
		case (erase_block_select)
			8'h80: begin erase_base = `FESR_EB7_BASE; erase_last = `FESR_EB7_LAST; end // R8
			8'h40: begin erase_base = `FESR_EB6_BASE; erase_last = `FESR_EB6_LAST; end // R8
			8'h20: begin erase_base = `FESR_EB5_BASE; erase_last = `FESR_EB5_LAST; end // R8
			8'h10: begin erase_base = `FESR_EB4_BASE; erase_last = `FESR_EB4_LAST; end // R8
			8'h08: begin erase_base = `FESR_EB3_BASE; erase_last = `FESR_EB3_LAST; end // R9
			8'h04: begin erase_base = `FESR_EB2_BASE; erase_last = `FESR_EB2_LAST; end // R9
			8'h02: begin erase_base = `FESR_EB1_BASE; erase_last = `FESR_EB1_LAST; end // R9
			8'h01: begin erase_base = `FESR_EB0_BASE; erase_last = `FESR_EB0_LAST; end // R9
			default: begin
				erase_base = `FESR_EB0_BASE;
				erase_last = `FESR_EB0_BASE;
				erase_valid = 1'b0;
			end
		endcase
	end
endmodule

// ===== rtl/fesr_overlay_map.sv
// Maps the fixed RAM window onto the chosen small flash block
`timescale 1ns/1ps
`include "fesr_map.svh"
module fesr_overlay_map
	import fesr_pkg::*;
(
	input wire logic overlay_enable, // Overlay active
	input wire logic [1:0] area_sel, // Area select high/low bits
	output fesr_addr_t overlay_flash_base, // Flash block covered
	output fesr_addr_t overlay_ram_base, // RAM window base
	output logic overlay_active // Overlay in force
);
	always_comb begin
		overlay_ram_base = `FESR_RAM_WIN_BASE;
		overlay_active = overlay_enable; // R10
		case (area_sel) // R12
			2'h0: overlay_flash_base = `FESR_EB0_BASE;
			2'h1: overlay_flash_base = `FESR_EB1_BASE;
			2'h2: overlay_flash_base = `FESR_EB2_BASE;
			2'h3: overlay_flash_base = `FESR_EB3_BASE;
			default: overlay_flash_base = `FESR_EB0_BASE;
		endcase
	end
endmodule

// ===== rtl/fesr_top.sv
// APB register block for flash error status, erase selection, RAM overlay and power control
`timescale 1ns/1ps
`include "fesr_map.svh"

// Function
// R1 - A failing program or erase operation sets error flag, status bit 7.
// R2 - While error flag is one, program and erase are blocked.
// R3 - Status register is read-only; writes to it change nothing.
// R4 - Unused status, power bits 6..0 and overlay bits 7..6 read zero.
// R5 - Erase selection is held at zero while software write enable is zero.
// R6 - With software write enable zero, setting erase selection bits is ignored.
// R7 - A write leaving several erase selection bits set clears them all.
// R8 - Erase bits 7..4 select the 8, 8, 16 and 28 kbyte blocks.
// R9 - Erase bits 3..0 select the four 1-kbyte blocks from address zero.
// R10 - Overlay enable maps RAM onto flash and protects every block.
// R11 - With overlay on, program and erase triggers do not enter those modes.
// R12 - Area select bits 2..1 pick the 1-kbyte block; bit 0 ignored.
// R13 - Software writes only zeros to overlay bits 5 and 4.
// R14 - Software avoids the emulated area right after changing overlay control.
// R15 - Software changes overlay control only in user or user program mode.
// R16 - Power-down inhibit set keeps flash powered on subactive entry.
// R17 - Power-down decision is taken only at the switch into subactive mode.
// R18 - Reset clears every defined bit of the four registers.
module fesr_top
	import fesr_pkg::*;
(
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic flash_op_error, // Pulse: program/erase failed
	input wire logic subactive_req, // Level: system in subactive mode
	input wire logic [1:0] ram_mode_ok, // Unused status of mode pins
	output logic program_mode, // Flash in program mode
	output logic erase_mode, // Flash in erase mode
	output logic flash_powerdown, // Flash power-down request
	output logic overlay_active, // RAM overlay in force
	output fesr_addr_t overlay_flash_base, // Overlaid flash block
	output fesr_addr_t overlay_ram_base, // RAM window base
	output fesr_addr_t erase_base, // Chosen erase block start
	output fesr_addr_t erase_last, // Chosen erase block end
	output logic erase_valid, // One erase block chosen
	output logic irq // Level interrupt
);
	logic err_q, err_d;
	logic [7:0] ebs_q, ebs_d;
	logic [5:0] ovl_q, ovl_d;
	logic pdi_q, pdi_d;
	logic [1:0] mode_q, mode_d;
	logic swe_q, swe_d;
	logic sub_q, sub_d;
	logic pdn_q, pdn_d;
	logic [`FESR_IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q_unused;
	logic wr, rd, mapped, protect, trig_set, sub_enter;
	logic [7:0] wb;
	logic [`FESR_IRQ_W-1:0] ev;

	assign wr = psel && penable && pwrite;
	// Read data captured at the setup edge so it stands through the access phase
	assign rd = psel && !penable && !pwrite;
	assign wb = pwdata[7:0];
	assign pready = 1'b1;
	assign err_q_unused = ^ram_mode_ok;
	assign mapped = (paddr == `FESR_OFF_ERR_STAT) || (paddr == `FESR_OFF_ERASE_SEL) ||
		(paddr == `FESR_OFF_OVL_CTRL) || (paddr == `FESR_OFF_PWR_CTRL) ||
		(paddr == `FESR_OFF_MODE_CTRL) || (paddr == `FESR_OFF_IRQ_STAT) ||
		(paddr == `FESR_OFF_IRQ_EN) || (paddr == `FESR_OFF_IRQ_CLR);
	assign pslverr = psel && penable && !mapped;
	assign prdata = rdata_q;
	// Error protection and emulation protection both veto any mode entry
	assign protect = err_q || ovl_q[`FESR_OVL_EN_BIT]; // R2 R10
	assign trig_set = wr && (paddr == `FESR_OFF_MODE_CTRL) &&
		(wb[`FESR_PROG_TRIG_BIT] || wb[`FESR_ERASE_TRIG_BIT]);
	assign sub_enter = subactive_req && !sub_q; // R17

	always_comb begin
		err_d = err_q;
		ebs_d = ebs_q;
		ovl_d = ovl_q;
		pdi_d = pdi_q;
		mode_d = mode_q;
		swe_d = swe_q;
		sub_d = subactive_req;
		pdn_d = pdn_q;
		ev = `FESR_IRQ_RST;
		if (flash_op_error && swe_q) begin
			err_d = 1'b1; // R1
		end
		// Status register has no write path
		if (wr && paddr == `FESR_OFF_MODE_CTRL) begin // R3
			swe_d = wb[`FESR_SWE_BIT];
			mode_d = wb[1:0];
		end
		if (protect || !swe_d) begin
			mode_d = 2'h0; // R11 R2
		end
		if (wr && paddr == `FESR_OFF_ERASE_SEL) begin
			ebs_d = wb; // R6
			if (!$onehot0(wb)) begin
				ebs_d = `FESR_RST8; // R7
			end
		end
		if (!swe_d) begin
			ebs_d = `FESR_RST8; // R5 R6
		end
		if (wr && paddr == `FESR_OFF_OVL_CTRL) begin
			ovl_d = wb[5:0];
		end
		if (wr && paddr == `FESR_OFF_PWR_CTRL) begin
			pdi_d = wb[`FESR_PDI_BIT];
		end
		if (sub_enter) begin
			pdn_d = !pdi_q; // R16 R17
		end else if (!subactive_req) begin
			pdn_d = 1'b0;
		end
		ev[`FESR_IRQ_ERROR] = flash_op_error && swe_q;
		ev[`FESR_IRQ_BLOCKED] = trig_set && protect;
		ev[`FESR_IRQ_PDN] = sub_enter && !pdi_q;
		ien_d = ien_q;
		ist_d = ist_q;
		if (wr && paddr == `FESR_OFF_IRQ_EN) begin
			ien_d = pwdata[`FESR_IRQ_W-1:0];
		end
		if (wr && paddr == `FESR_OFF_IRQ_CLR) begin
			ist_d = ist_q & ~pwdata[`FESR_IRQ_W-1:0];
		end
		// Set after clear so a coincident event is kept
		ist_d = ist_d | ev;
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd) begin
			case (paddr)
				`FESR_OFF_ERR_STAT: rdata_d[`FESR_ERR_FLAG_BIT] = err_q; // R4
				`FESR_OFF_ERASE_SEL: rdata_d[7:0] = ebs_q;
				`FESR_OFF_OVL_CTRL: rdata_d[5:0] = ovl_q; // R4
				`FESR_OFF_PWR_CTRL: rdata_d[`FESR_PDI_BIT] = pdi_q; // R4
				`FESR_OFF_MODE_CTRL: begin
					rdata_d[`FESR_SWE_BIT] = swe_q;
					rdata_d[1:0] = mode_q;
				end
				`FESR_OFF_IRQ_STAT: rdata_d[`FESR_IRQ_W-1:0] = ist_q;
				`FESR_OFF_IRQ_EN: rdata_d[`FESR_IRQ_W-1:0] = ien_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 1'b0; // R18
			ebs_q <= `FESR_RST8;
			ovl_q <= 6'h00;
			pdi_q <= 1'b0;
			mode_q <= 2'h0;
			swe_q <= 1'b0;
			sub_q <= 1'b0;
			pdn_q <= 1'b0;
			ist_q <= `FESR_IRQ_RST;
			ien_q <= `FESR_IRQ_RST;
			rdata_q <= 32'h0000_0000;
		end else begin
			err_q <= err_d;
			ebs_q <= ebs_d;
			ovl_q <= ovl_d;
			pdi_q <= pdi_d;
			mode_q <= mode_d;
			swe_q <= swe_d;
			sub_q <= sub_d;
			pdn_q <= pdn_d;
			ist_q <= ist_d;
			ien_q <= ien_d;
			rdata_q <= rdata_d;
		end
	end

	assign program_mode = mode_q[`FESR_PROG_TRIG_BIT] && !protect;
	assign erase_mode = mode_q[`FESR_ERASE_TRIG_BIT] && !protect && erase_valid;
	assign flash_powerdown = pdn_q;
	assign irq = |(ist_q & ien_q);

	fesr_erase_decode u_dec (
		.erase_block_select(ebs_q),
		.erase_base(erase_base),
		.erase_last(erase_last),
		.erase_valid(erase_valid)
	);

	fesr_overlay_map u_ovl (
		.overlay_enable(ovl_q[`FESR_OVL_EN_BIT]),
		.area_sel(ovl_q[`FESR_OVL_SEL_HI_BIT:`FESR_OVL_SEL_LO_BIT]), // R12
		.overlay_flash_base(overlay_flash_base),
		.overlay_ram_base(overlay_ram_base),
		.overlay_active(overlay_active)
	);
endmodule

// ===== verif/fesr_properties.sv
// Port-level checker for the flash control block
`timescale 1ns/1ps
module fesr_properties
	import fesr_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic subactive_req, // Subactive level
	input wire logic program_mode, // Program mode
	input wire logic erase_mode, // Erase mode
	input wire logic flash_powerdown, // Power-down
	input wire logic overlay_active, // Overlay on
	input wire fesr_addr_t overlay_flash_base, // Overlaid block
	input wire fesr_addr_t overlay_ram_base, // RAM window
	input wire logic erase_valid // One block chosen
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_phase;
		psel && penable;
	endsequence
	sequence pd_rise;
		$rose(flash_powerdown);
	endsequence
	prot_mode_a: assert property (overlay_active |-> !program_mode && !erase_mode)
		else $error("mode entered under overlay");
	pd_cause_a: assert property (pd_rise |-> $past(subactive_req))
		else $error("power-down without subactive entry");
	pd_hold_a: assert property (flash_powerdown && subactive_req |=> flash_powerdown)
		else $error("power-down lost inside subactive");
	pd_drop_a: assert property ($fell(subactive_req) |-> ##[0:2] !flash_powerdown)
		else $error("power-down kept after subactive exit");
	slv_err_a: assert property (pslverr |-> acc_phase)
		else $error("error outside access phase");
	ready_acc_a: assert property (acc_phase |-> pready)
		else $error("access phase not answered");
	ram_base_a: assert property (overlay_ram_base == 24'hFFE000)
		else $error("RAM window base wrong");
	ovl_base_a: assert property (overlay_active |-> overlay_flash_base[9:0] == 10'h000
		&& overlay_flash_base[23:12] == 12'h000)
		else $error("overlaid block outside small blocks");
	erase_one_a: assert property (erase_mode |-> erase_valid)
		else $error("erase without single block");
	rd_upper_a: assert property (prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
endmodule
bind fesr_top fesr_properties u_fesr_properties (.pclk, .presetn, .psel, .penable, .prdata,
	.pready, .pslverr, .subactive_req, .program_mode, .erase_mode, .flash_powerdown,
	.overlay_active, .overlay_flash_base, .overlay_ram_base, .erase_valid);

// ===== verif/fesr_top_tb.sv
// Register-level testbench for the flash control block
`timescale 1ns/1ps
`include "fesr_map.svh"
module fesr_top_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic flash_op_error = 1'b0, subactive_req = 1'b0, serr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0] ram_mode_ok = 2'h2;
	logic pready, pslverr, program_mode, erase_mode, flash_powerdown, overlay_active;
	logic erase_valid, irq;
	logic [23:0] overlay_flash_base, overlay_ram_base, erase_base, erase_last;
	int n_errors = 0, checked = 0;
	logic [23:0] eb_b [8] = '{`FESR_EB0_BASE, `FESR_EB1_BASE, `FESR_EB2_BASE, `FESR_EB3_BASE,
		`FESR_EB4_BASE, `FESR_EB5_BASE, `FESR_EB6_BASE, `FESR_EB7_BASE};
	logic [23:0] eb_l [8] = '{`FESR_EB0_LAST, `FESR_EB1_LAST, `FESR_EB2_LAST, `FESR_EB3_LAST,
		`FESR_EB4_LAST, `FESR_EB5_LAST, `FESR_EB6_LAST, `FESR_EB7_LAST};
	fesr_top u_fesr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .flash_op_error, .subactive_req, .ram_mode_ok, .program_mode,
		.erase_mode, .flash_powerdown, .overlay_active, .overlay_flash_base,
		.overlay_ram_base, .erase_base, .erase_last, .erase_valid, .irq);
	initial forever #2.5 pclk = ~pclk;
	task test_done;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task cb(input string n, input logic g, input logic e);
		chk(n, {31'h0, g}, {31'h0, e});
	endtask
	// Response taken at the ready edge; returns at the falling edge so outputs have settled
	task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		serr = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		ap(1'b1, a, d);
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		ap(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rd, e);
	endtask
	task sub(input logic v, input logic e);
		@(posedge pclk);
		subactive_req <= v;
		repeat (3) @(posedge pclk);
		#1 cb("powerdown", flash_powerdown, e);
	endtask
	initial begin
		#20000;
		n_errors++;
		test_done;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rc(12'(i * 4), 32'h0);
		ap(1'b0, 12'h020, 32'h0);
		cb("slverr", serr, 1'b1);
		chk("unmapped", rd, 32'h0);
		$display("test reset values done");
		wr(12'h000, 32'hFF);
		rc(12'h000, 32'h0);
		wr(12'h004, 32'h01);
		rc(12'h004, 32'h0);
		wr(12'h010, 32'h40);
		for (int i = 0; i < 8; i++) begin
			wr(12'h004, 32'h1 << i);
			rc(12'h004, 32'h1 << i);
			chk("erase base", {8'h00, erase_base}, {8'h00, eb_b[i]});
			chk("erase last", {8'h00, erase_last}, {8'h00, eb_l[i]});
		end
		wr(12'h004, 32'h03);
		rc(12'h004, 32'h0);
		cb("erase valid", erase_valid, 1'b0);
		wr(12'h004, 32'h01);
		wr(12'h010, 32'h42);
		cb("erase mode", erase_mode, 1'b1);
		wr(12'h010, 32'h41);
		cb("program mode", program_mode, 1'b1);
		wr(12'h010, 32'h40);
		$display("test erase done");
		for (int s = 0; s < 4; s++) begin
			wr(12'h008, 32'h09 | (s << 1));
			rc(12'h008, 32'h09 | (s << 1));
			chk("ovl base", {8'h00, overlay_flash_base}, 32'h400 * s);
			cb("ovl active", overlay_active, 1'b1);
			wr(12'h010, 32'h41);
			cb("prog blocked", program_mode, 1'b0);
		end
		wr(12'h008, 32'hCF);
		rc(12'h008, 32'h0F);
		wr(12'h008, 32'h0);
		wr(12'h010, 32'h40);
		$display("test overlay done");
		wr(12'h00C, 32'hFF);
		rc(12'h00C, 32'h80);
		sub(1'b1, 1'b0);
		sub(1'b0, 1'b0);
		wr(12'h00C, 32'h0);
		sub(1'b1, 1'b1);
		wr(12'h00C, 32'h80);
		cb("pd kept", flash_powerdown, 1'b1);
		sub(1'b0, 1'b0);
		$display("test power done");
		wr(12'h018, 32'h0);
		wr(12'h01C, 32'h7);
		@(posedge pclk);
		flash_op_error <= 1'b1;
		@(posedge pclk);
		flash_op_error <= 1'b0;
		rc(12'h000, 32'h80);
		cb("irq masked", irq, 1'b0);
		rc(12'h014, 32'h1);
		wr(12'h018, 32'h7);
		cb("irq on", irq, 1'b1);
		wr(12'h010, 32'h41);
		cb("err blocks", program_mode, 1'b0);
		rc(12'h014, 32'h3);
		wr(12'h01C, 32'h3);
		rc(12'h014, 32'h0);
		cb("irq off", irq, 1'b0);
		$display("test error done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rc(12'h000, 32'h0);
		rc(12'h010, 32'h0);
		cb("irq reset", irq, 1'b0);
		$display("test reset done");
		test_done;
	end
endmodule
